// ==== rtl/spm_pkg.sv ====
// Shared constants for the scratchpad memory command handler and its master.
// Assumes a single 40 MHz system clock common to both ends.
package spm_pkg;
  localparam logic [7:0] CMD_WRITE_SP = 8'h0F;
  localparam logic [7:0] CMD_READ_SP  = 8'hAA;
  localparam logic [7:0] CMD_COPY_SP  = 8'h55;
  localparam logic [7:0] CMD_READ_MEM = 8'hF0;
  localparam int SP_BYTES  = 32;
  localparam int MEM_BYTES = 8192;
  localparam logic [16:0] MEM_TOP = 17'h01FFF;
  localparam logic [7:0]  ONES    = 8'hFF;
  // Ending offset / status field layout
  localparam int ES_AUTH_BIT = 7;
  localparam int ES_OVF_BIT  = 6;
  localparam int ES_PART_BIT = 5;
  localparam logic [7:0] ES_RESET = 8'h00;
  localparam logic [7:0] TA_RESET = 8'h00;
  // Copy time and its cycle count at the system clock
  localparam int CLK_PERIOD_PS = 25000;
  localparam int COPY_TIME_US  = 30;
  localparam int COPY_CYC      = (COPY_TIME_US * 1000000) / CLK_PERIOD_PS;
  // Master register port
  localparam logic [3:0] REG_DATA   = 4'h0;
  localparam logic [3:0] REG_CTRL   = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam int CTRL_KIND_LSB = 0;
  localparam int CTRL_BITS_LSB = 2;
  typedef enum logic [1:0] {
    OP_RESET = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ  = 2'h2
  } spm_op_t;
endpackage

// ==== rtl/spm_link_if.sv ====
// Bit-slot link between the bus master and the memory device.
// Slot timing and wire levels are abstracted into one-cycle strobes.
`timescale 1ns/1ps
interface spm_link_if (
  input wire logic sysClk
);
  logic slotStrobe;
  logic slotWrite;
  logic slotBit;
  logic resetPulse;
  logic answerValid;
  logic answerBit;
  modport master (
    output slotStrobe,
    output slotWrite,
    output slotBit,
    output resetPulse,
    input  answerValid,
    input  answerBit
  );
  modport device (
    input  slotStrobe,
    input  slotWrite,
    input  slotBit,
    input  resetPulse,
    output answerValid,
    output answerBit
  );
endinterface

// ==== rtl/spm_device.sv ====
// Memory function command handler of the serial memory device.
// Assumes the master has already completed the ROM-level selection; a reset
// pulse on the link outside a copy returns the handler to awaiting a command byte.
`timescale 1ns/1ps
module spm_device #(
  parameter int MEM_SIZE = spm_pkg::MEM_BYTES,
  parameter int COPY_CYCLES = spm_pkg::COPY_CYC
) (
  input  wire logic  sysClk,
  input  wire logic  rst,
  spm_link_if.device link,
  output logic [7:0] targetAddrLow,
  output logic [7:0] targetAddrHigh,
  output logic [7:0] endingOffsetStatus,
  output logic       copyActive
);
  import spm_pkg::*;

  initial begin
    if (MEM_SIZE != MEM_BYTES || COPY_CYCLES <= SP_BYTES ||
        COPY_CYCLES > 2047) begin
      $error("spm_device: unsupported parameter values");
    end
  end

  typedef enum logic [9:0] {
    ST_CMD   = 10'h001,
    ST_ALO   = 10'h002,
    ST_AHI   = 10'h004,
    ST_WRSP  = 10'h008,
    ST_RDSP  = 10'h010,
    ST_AUTH  = 10'h020,
    ST_COPY  = 10'h040,
    ST_DONE  = 10'h080,
    ST_RDMEM = 10'h100,
    ST_IDLE  = 10'h200
  } spm_dev_state_t;

  typedef struct packed {
    spm_dev_state_t state;
    logic [7:0]     cmd;
    logic [7:0]     sh;
    logic [2:0]     bitCnt;
    logic [7:0]     taLo;
    logic [7:0]     taHi;
    logic [7:0]     es;
    logic [5:0]     spOff;
    logic           full;
    logic [1:0]     idx;
    logic [16:0]    memAddr;
    logic           authOk;
    logic [4:0]     cpOff;
    logic           cpDone;
    logic [10:0]    cpTimer;
    logic           ansValid;
    logic           ansBit;
    logic           copyRun;
  } spm_dev_regs_t;

  spm_dev_regs_t r_q;
  spm_dev_regs_t r_d;

  logic [7:0]  scratch [SP_BYTES];
  logic [7:0]  mem [MEM_SIZE];
  logic        spWe;
  logic [4:0]  spWa;
  logic [7:0]  spWd;
  logic        memWe;
  logic [12:0] memWa;
  logic [7:0]  txByte;
  logic [7:0]  rxByte;
  logic        byteEnd;

  // Byte the device is presenting in the current read state
  function automatic logic [7:0] tx_select(spm_dev_regs_t s,
                                           logic [7:0] spData,
                                           logic [7:0] memData);
    logic [7:0] v;
    v = ONES;
    case (s.state)
      ST_RDSP: begin
        case (s.idx)
          2'd0:    v = s.taLo;
          2'd1:    v = s.taHi;
          2'd2:    v = s.es;
          default: v = s.spOff[5] ? ONES : spData;
        endcase
      end
      ST_RDMEM: v = (s.memAddr > MEM_TOP) ? ONES : memData;
      ST_DONE:  v = 8'h00;
      default:  v = ONES;
    endcase
    return v;
  endfunction

  assign txByte = tx_select(r_q, scratch[r_q.spOff[4:0]],
                            mem[r_q.memAddr[12:0]]);
  assign rxByte = {link.slotBit, r_q.sh[7:1]};
  assign byteEnd = (r_q.bitCnt == 3'd7);
  assign memWa = {r_q.taHi[4:0], r_q.taLo[7:5], r_q.cpOff};

  always_comb begin
    r_d = r_q;
    r_d.ansValid = 1'b0;
    spWe = 1'b0;
    spWa = r_q.spOff[4:0];
    spWd = rxByte;
    memWe = 1'b0;
    if (r_q.state == ST_COPY) begin
      // Copy runs on its own; link strobes and resets are not looked at
      if (!r_q.cpDone) begin
        memWe = 1'b1;
        if (r_q.cpOff == r_q.es[4:0]) begin
          r_d.cpDone = 1'b1;
        end else begin
          r_d.cpOff = r_q.cpOff + 5'd1;
        end
      end
      r_d.cpTimer = r_q.cpTimer + 11'd1;
      if (r_q.cpTimer == 11'(COPY_CYCLES - 1)) begin
        r_d.state = ST_DONE;
      end
    end else if (link.resetPulse) begin
      if (r_q.state == ST_WRSP && r_q.bitCnt != 3'd0) begin
        r_d.es[ES_PART_BIT] = 1'b1;
        if (!r_q.full) begin
          // Partial bits land as a whole byte, unsent bits zero
          spWe = 1'b1;
          spWd = r_q.sh >> (4'd8 - {1'b0, r_q.bitCnt});
          r_d.es[4:0] = r_q.spOff[4:0];
        end
      end
      r_d.state = ST_CMD;
      r_d.bitCnt = 3'd0;
    end else if (link.slotStrobe && !link.slotWrite) begin
      r_d.ansValid = 1'b1;
      r_d.ansBit = txByte[r_q.bitCnt];
      r_d.bitCnt = r_q.bitCnt + 3'd1;
      if (byteEnd) begin
        if (r_q.state == ST_RDSP) begin
          if (r_q.idx != 2'd3) begin
            r_d.idx = r_q.idx + 2'd1;
          end else if (!r_q.spOff[5]) begin
            r_d.spOff = r_q.spOff + 6'd1;
          end
        end else if (r_q.state == ST_RDMEM && r_q.memAddr <= MEM_TOP) begin
          r_d.memAddr = r_q.memAddr + 17'd1;
        end
      end
    end else if (link.slotStrobe) begin
      r_d.sh = rxByte;
      r_d.bitCnt = r_q.bitCnt + 3'd1;
      if (r_q.state == ST_WRSP && r_q.full) begin
        r_d.es[ES_OVF_BIT] = 1'b1;
      end
      if (byteEnd) begin
        case (r_q.state)
          ST_CMD: begin
            r_d.cmd = rxByte;
            r_d.idx = 2'd0;
            r_d.authOk = 1'b1;
            case (rxByte)
              CMD_WRITE_SP, CMD_READ_MEM: r_d.state = ST_ALO;
              CMD_READ_SP: begin
                r_d.state = ST_RDSP;
                r_d.spOff = {1'b0, r_q.taLo[4:0]};
              end
              CMD_COPY_SP: r_d.state = ST_AUTH;
              default:     r_d.state = ST_IDLE;
            endcase
          end
          ST_ALO: begin
            r_d.taLo = rxByte;
            r_d.state = ST_AHI;
          end
          ST_AHI: begin
            r_d.taHi = rxByte;
            if (r_q.cmd == CMD_WRITE_SP) begin
              r_d.state = ST_WRSP;
              r_d.spOff = {1'b0, r_q.taLo[4:0]};
              r_d.full = 1'b0;
              r_d.es[ES_AUTH_BIT] = 1'b0;
              r_d.es[ES_OVF_BIT] = 1'b0;
              r_d.es[ES_PART_BIT] = 1'b0;
              r_d.es[4:0] = r_q.taLo[4:0];
            end else begin
              r_d.state = ST_RDMEM;
              r_d.memAddr = {1'b0, rxByte, r_q.taLo};
            end
          end
          ST_WRSP: begin
            if (!r_q.full) begin
              spWe = 1'b1;
              r_d.es[4:0] = r_q.spOff[4:0];
              if (r_q.spOff[4:0] == 5'h1F) begin
                r_d.full = 1'b1;
              end else begin
                r_d.spOff = r_q.spOff + 6'd1;
              end
            end
          end
          ST_AUTH: begin
            // Status is only compared here, never loaded from the link
            case (r_q.idx)
              2'd0:    r_d.authOk = r_q.authOk & (rxByte == r_q.taLo);
              2'd1:    r_d.authOk = r_q.authOk & (rxByte == r_q.taHi);
              default: r_d.authOk = r_q.authOk & (rxByte == r_q.es);
            endcase
            r_d.idx = r_q.idx + 2'd1;
            if (r_q.idx == 2'd2) begin
              if (r_q.authOk && rxByte == r_q.es) begin
                r_d.es[ES_AUTH_BIT] = 1'b1;
                r_d.state = ST_COPY;
                r_d.cpOff = r_q.taLo[4:0];
                r_d.cpDone = 1'b0;
                r_d.cpTimer = 11'd0;
              end else begin
                r_d.state = ST_IDLE;
              end
            end
          end
          default: r_d.state = r_q.state;
        endcase
      end
    end
    // Registered so the copy indicator leaves straight from a flip-flop
    r_d.copyRun = (r_d.state == ST_COPY);
  end

  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      r_q <= '{state: ST_CMD, taLo: TA_RESET, taHi: TA_RESET,
               es: ES_RESET, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  // Storage arrays carry no reset; contents are undefined until written
  always_ff @(posedge sysClk) begin
    if (spWe) begin
      scratch[spWa] <= spWd;
    end
    if (memWe) begin
      mem[memWa] <= scratch[r_q.cpOff];
    end
  end

  assign link.answerValid = r_q.ansValid;
  assign link.answerBit = r_q.ansBit;
  assign targetAddrLow = r_q.taLo;
  assign targetAddrHigh = r_q.taHi;
  assign endingOffsetStatus = r_q.es;
  assign copyActive = r_q.copyRun;
endmodule // spm_device

// ==== rtl/spm_master.sv ====
// Bus master end: turns register orders into reset pulses and bit slots.
// Assumes the device answers each read slot a cycle after the strobe.
`timescale 1ns/1ps
module spm_master (
  input  wire logic  sysClk,
  input  wire logic  rst,
  spm_link_if.master link,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic [7:0]      regRdata,
  output logic            busy
);
  import spm_pkg::*;

  typedef enum logic [2:0] {
    MS_IDLE = 3'h1,
    MS_GAP  = 3'h2,
    MS_WAIT = 3'h4
  } spm_ms_state_t;

  typedef struct packed {
    spm_ms_state_t state;
    spm_op_t       kind;
    logic [3:0]    bitsLeft;
    logic [7:0]    txData;
    logic [7:0]    rxData;
    logic          strobe;
    logic          wrSlot;
    logic          bitOut;
    logic          rstPulse;
    logic          done;
    logic [7:0]    rdata;
    logic          busy;
  } spm_ms_regs_t;

  spm_ms_regs_t r_q;
  spm_ms_regs_t r_d;
  logic         slotGo;

  always_comb begin
    r_d = r_q;
    r_d.strobe = 1'b0;
    r_d.rstPulse = 1'b0;
    slotGo = 1'b0;
    case (r_q.state)
      MS_IDLE: begin
        if (regWr && regAddr == REG_DATA) begin
          r_d.txData = regWdata;
        end else if (regWr && regAddr == REG_CTRL) begin
          r_d.kind = spm_op_t'(regWdata[CTRL_KIND_LSB +: 2]);
          r_d.bitsLeft = (regWdata[CTRL_BITS_LSB +: 4] == 4'd0 ||
                          regWdata[CTRL_BITS_LSB +: 4] > 4'd8) ?
                         4'd8 : regWdata[CTRL_BITS_LSB +: 4];
          r_d.done = 1'b0;
          if (spm_op_t'(regWdata[CTRL_KIND_LSB +: 2]) == OP_RESET) begin
            r_d.rstPulse = 1'b1;
            r_d.done = 1'b1;
          end else begin
            r_d.state = MS_GAP;
          end
        end
      end
      MS_GAP: begin
        // One idle cycle between write slots, two between read slots, keeps strobes apart
        slotGo = 1'b1;
      end
      MS_WAIT: begin
        if (link.answerValid) begin
          r_d.rxData = {link.answerBit, r_q.rxData[7:1]};
          r_d.state = (r_q.bitsLeft == 4'd0) ? MS_IDLE : MS_GAP;
          r_d.done = (r_q.bitsLeft == 4'd0);
        end
      end
      default: r_d.state = MS_IDLE;
    endcase
    if (slotGo) begin
      r_d.strobe = 1'b1;
      r_d.wrSlot = (r_q.kind == OP_WRITE);
      r_d.bitOut = r_q.txData[0];
      r_d.txData = {1'b1, r_q.txData[7:1]};
      r_d.bitsLeft = r_q.bitsLeft - 4'd1;
      if (r_q.kind == OP_WRITE) begin
        r_d.state = (r_q.bitsLeft == 4'd1) ? MS_IDLE : MS_GAP;
        r_d.done = (r_q.bitsLeft == 4'd1);
        if (r_q.bitsLeft != 4'd1) begin
          r_d.state = MS_WAIT;
        end
      end else begin
        r_d.state = MS_WAIT;
      end
    end
    if (r_q.state == MS_WAIT && r_q.kind == OP_WRITE) begin
      r_d.state = MS_GAP;
    end
    r_d.rdata = 8'h00;
    if (regRd) begin
      case (regAddr)
        REG_DATA:   r_d.rdata = r_q.rxData;
        REG_STATUS: r_d.rdata = {6'h00, r_q.done, r_q.state != MS_IDLE};
        default:    r_d.rdata = 8'h00;
      endcase
    end
    r_d.busy = (r_d.state != MS_IDLE);
  end

  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      r_q <= '{state: MS_IDLE, kind: OP_RESET, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign link.slotStrobe = r_q.strobe;
  assign link.slotWrite = r_q.wrSlot;
  assign link.slotBit = r_q.bitOut;
  assign link.resetPulse = r_q.rstPulse;
  assign regRdata = r_q.rdata;
  assign busy = r_q.busy;
endmodule // spm_master

// ==== dv/spm_link_checker.sv ====
// Assertions on the link between the master and device ends.
// Assumes one instance beside the link that joins the two design ends.
`timescale 1ns/1ps
module spm_link_checker #(
  parameter int COPY_CYCLES = 40
) (
  input wire logic       sysClk,
  input wire logic       rst,
  input wire logic       slotStrobe,
  input wire logic       slotWrite,
  input wire logic       slotBit,
  input wire logic       resetPulse,
  input wire logic       answerValid,
  input wire logic       answerBit,
  input wire logic [7:0] endingOffsetStatus,
  input wire logic       copyActive
);
  int   copyCnt_q;
  logic postCopy_q;
  default clocking cb @(posedge sysClk); endclocking
  default disable iff (rst);
  // Counts copy length; flag marks the idle span after a finished copy
  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      copyCnt_q  <= 0;
      postCopy_q <= 1'b0;
    end else begin
      copyCnt_q <= copyActive ? copyCnt_q + 1 : 0;
      if (resetPulse && !copyActive) postCopy_q <= 1'b0;
      else if (!copyActive && copyCnt_q != 0) postCopy_q <= 1'b1;
    end
  end
  property p_ansAfterRead;
    slotStrobe && !slotWrite && !copyActive |=> answerValid;
  endproperty
  a_ansAfterRead: assert property (p_ansAfterRead)
    else $error("read slot without answer");
  property p_noSpurious;
    answerValid |-> $past(slotStrobe && !slotWrite);
  endproperty
  a_noSpurious: assert property (p_noSpurious)
    else $error("answer without read slot");
  property p_ansPulse;
    answerValid |=> !answerValid;
  endproperty
  a_ansPulse: assert property (p_ansPulse)
    else $error("answer longer than one cycle");
  property p_slotGap;
    slotStrobe |=> !slotStrobe && !resetPulse;
  endproperty
  a_slotGap: assert property (p_slotGap)
    else $error("slots too close");
  property p_copyLen;
    $fell(copyActive) |->
      copyCnt_q >= COPY_CYCLES - 1 && copyCnt_q <= COPY_CYCLES + 1;
  endproperty
  a_copyLen: assert property (p_copyLen)
    else $error("copy length wrong");
  property p_copyZeros;
    answerValid && postCopy_q |-> !answerBit;
  endproperty
  a_copyZeros: assert property (p_copyZeros)
    else $error("nonzero answer after copy");
  property p_copyNeedsAuth;
    $rose(copyActive) |-> endingOffsetStatus[7];
  endproperty
  a_copyNeedsAuth: assert property (p_copyNeedsAuth)
    else $error("copy without accepted flag");
  property p_statusFrozen;
    copyActive && $past(copyActive) |-> $stable(endingOffsetStatus);
  endproperty
  a_statusFrozen: assert property (p_statusFrozen)
    else $error("status changed during copy");
  c_copy: cover property ($fell(copyActive));
  c_zeroAns: cover property (answerValid && postCopy_q);
  c_oneWrite: cover property (slotStrobe && slotWrite && slotBit);
endmodule // spm_link_checker

// ==== dv/scratchpad_memory_commands_bench.sv ====
// Bench joining master and device ends; drives the master register port.
// Assumes short copy time through the device parameter.
`timescale 1ns/1ps
module scratchpad_memory_commands_bench;
  import spm_pkg::*;
  localparam int CC = 40;
  logic        sysClk   = 1'b0;
  logic        rst      = 1'b1;
  logic [3:0]  regAddr  = 4'h0;
  logic [7:0]  regWdata = 8'h00;
  logic        regWr    = 1'b0;
  logic        regRd    = 1'b0;
  logic        rdSeen   = 1'b0;
  logic [7:0]  regRdata, tgtLow, tgtHigh, es, e;
  logic        busy, copyActive;
  logic [31:0] seed = 32'h78CD;
  logic [7:0]  pad [0:4];
  logic [7:0]  q [$];
  int          err_count = 0;
  int          compares  = 0;
  spm_link_if link (.sysClk(sysClk));
  spm_master spm_master_i (.sysClk(sysClk), .rst(rst), .link(link.master),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .busy(busy));
  spm_device #(.COPY_CYCLES(CC)) spm_device_i (.sysClk(sysClk), .rst(rst),
    .link(link.device), .targetAddrLow(tgtLow), .targetAddrHigh(tgtHigh),
    .endingOffsetStatus(es), .copyActive(copyActive));
  spm_link_checker #(.COPY_CYCLES(CC)) spm_link_checker_i (
    .sysClk(sysClk), .rst(rst), .slotStrobe(link.slotStrobe),
    .slotWrite(link.slotWrite), .slotBit(link.slotBit),
    .resetPulse(link.resetPulse), .answerValid(link.answerValid),
    .answerBit(link.answerBit), .endingOffsetStatus(es),
    .copyActive(copyActive));
  always #12.5 sysClk = ~sysClk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tally_and_finish();
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // A gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge sysClk);
    regWr <= 1'b0;
    @(posedge sysClk);
  endtask
  task automatic op(input logic [1:0] k, input logic [3:0] n,
                    input logic [7:0] d);
    int w;
    w = 0;
    wr(REG_DATA, d);
    wr(REG_CTRL, {2'b00, n, k});
    while (busy !== 1'b0 && w < 200) begin
      @(posedge sysClk);
      w++;
    end
    // The device takes the last slot at this edge; let it settle
    @(posedge sysClk);
    if (w == 200) chk(8'h00, 8'h01);
  endtask
  task automatic wb(input logic [7:0] d);
    op(OP_WRITE, 4'h8, d);
  endtask
  task automatic rp();
    wr(REG_CTRL, 8'h00);
    @(posedge sysClk);
  endtask
  task automatic rdb(input logic [7:0] exp);
    op(OP_READ, 4'h8, 8'h00);
    q.push_back(exp);
    regAddr <= REG_DATA;
    regRd   <= 1'b1;
    @(posedge sysClk);
    regRd <= 1'b0;
    @(posedge sysClk);
  endtask
  task automatic copyWait();
    int w;
    w = 0;
    while (copyActive !== 1'b0 && w < CC + 50) begin
      @(posedge sysClk);
      w++;
    end
    chk({7'h00, copyActive}, 8'h00);
  endtask
  always @(posedge sysClk) begin
    if (rdSeen) begin
      e = (q.size() > 0) ? q.pop_front() : 8'hXX;
      chk(regRdata, e);
    end
    rdSeen <= regRd;
  end
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge sysClk);
    rst <= 1'b0;
    @(posedge sysClk);
    // Offset 1C fills after four bytes; the fifth overflows
    rp();
    wb(CMD_WRITE_SP);
    wb(8'h3C);
    wb(8'h01);
    for (int i = 0; i < 5; i++) begin
      seed   = lfsr(seed);
      pad[i] = seed[7:0];
      wb(pad[i]);
    end
    chk(tgtLow, 8'h3C);
    chk(tgtHigh, 8'h01);
    chk(es, 8'h5F);
    rp();
    wb(CMD_READ_SP);
    rdb(8'h3C);
    rdb(8'h01);
    rdb(8'h5F);
    for (int i = 0; i < 4; i++) rdb(pad[i]);
    rdb(8'hFF);
    // Wrong authorization must leave everything alone
    rp();
    wb(CMD_COPY_SP);
    wb(8'h3C);
    wb(8'h01);
    wb(8'h1F);
    chk(es, 8'h5F);
    chk({7'h00, copyActive}, 8'h00);
    rp();
    wb(8'h33);
    rdb(8'hFF);
    chk(tgtLow, 8'h3C);
    rp();
    wb(CMD_WRITE_SP);
    wb(8'h26);
    wb(8'h00);
    wb(pad[0]);
    wb(pad[1]);
    chk(es, 8'h07);
    rp();
    wb(CMD_COPY_SP);
    wb(8'h26);
    wb(8'h00);
    wb(8'h07);
    chk(es, 8'h87);
    rp();
    copyWait();
    rdb(8'h00);
    rp();
    chk(es, 8'h87);
    wb(CMD_READ_MEM);
    wb(8'h26);
    wb(8'h00);
    rdb(pad[0]);
    rdb(pad[1]);
    // Three bits only: partial flag, and copied as a whole byte
    rp();
    wb(CMD_WRITE_SP);
    wb(8'h00);
    wb(8'h00);
    op(OP_WRITE, 4'h3, 8'h05);
    // The partial flag is raised when the reset pulse ends the write
    rp();
    chk(es, 8'h20);
    wb(CMD_COPY_SP);
    wb(8'h00);
    wb(8'h00);
    wb(8'h20);
    copyWait();
    rp();
    wb(CMD_READ_MEM);
    wb(8'h00);
    wb(8'h00);
    rdb(8'h05);
    rp();
    repeat (4) @(posedge sysClk);
    tally_and_finish();
  end
endmodule // scratchpad_memory_commands_bench
